/* bench/test_vpa_core.sv */
// test_vpa_core.sv: self-checking bench for the planar access core.
// assumes the core, its register header and the plane memory model.
`timescale 1ns/1ps
`include "vpa_regs.vh"
module test_vpa_core;
  typedef struct packed {
    logic        w;
    logic [71:0] cfg; // am rot sen sval cc ign rps bm dat
    logic [31:0] exp;
  } vpa_row_t;
  logic        clock = 1'b0, nrst = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0]  io_index = 8'h00, io_wdata = 8'h00, host_wdata = 8'h00, io_rdata, host_rdata, rd;
  logic        pci_mem_en = 1'b1, misc_ram_en = 1'b1, host_req = 1'b0, host_we = 1'b0;
  logic [3:0]  plane_mask_ctrl = 4'hF, plane_we, seen_we;
  logic [19:0] host_addr = 20'h00000;
  logic        host_ack, host_hit, plane_rd, gfx_mode;
  logic [27:0] plane_addr, seen_a;
  logic [31:0] plane_wdata, plane_rdata, seen_w;
  int          bad_count = 0, checked = 0;
  // latches always come from offset 10, writes land at 20
  vpa_row_t rows [11] = '{
    {1'b1, 72'h00_00_00_00_00_00_00_FF_81, 32'h81818181},
    {1'b1, 72'h00_0B_00_00_00_00_00_FF_81, 32'h00302010},
    {1'b1, 72'h00_04_05_01_00_00_00_FF_12, 32'h210021FF},
    {1'b1, 72'h00_18_00_00_00_00_00_FF_FF, 32'h3CC35AA5},
    {1'b1, 72'h00_10_00_00_00_00_00_3C_0F, 32'hCF3CAD5E},
    {1'b1, 72'h01_00_00_00_00_00_00_0F_00, 32'hC33CA55A},
    {1'b1, 72'h02_00_00_00_00_00_00_F0_05, 32'h03FC05FA},
    {1'b1, 72'h03_00_00_03_00_00_00_F0_3C, 32'hC30CB57A},
    {1'b0, 72'h00_00_00_00_00_00_02_FF_00, 32'h0000003C},
    {1'b0, 72'h08_00_00_00_01_03_00_FF_00, 32'h0000005A},
    {1'b0, 72'h08_00_00_00_00_00_00_FF_00, 32'h000000FF}};
  logic [7:0]  ridx [8] = '{`VPA_IDX_AMODE, `VPA_IDX_ROT, `VPA_IDX_SR_EN, `VPA_IDX_SR_VAL,
                            `VPA_IDX_CC_VAL, `VPA_IDX_IGN, `VPA_IDX_RPS, `VPA_IDX_BMASK};
  logic [19:0] ap [4] = '{20'hA8000, 20'hB0000, 20'hB8000, 20'hC0000}; // probe addresses
  logic [3:0]  hm [4] = '{4'h3, 4'h5, 4'h9, 4'h0}; // map codes that claim each probe
  // misc, access mode, plane mask, address, expected plane enables
  logic [43:0] oe [4] = '{{8'h02, 8'h00, 4'hF, 20'hA0001, 4'hA},
    {8'h02, 8'h00, 4'hF, 20'hA0002, 4'h5}, {8'h00, 8'h10, 4'h3, 20'hA0003, 4'h2},
    {8'h00, 8'h00, 4'h6, 20'hA0005, 4'h6}};
  // plane addresses of the rows: A0 gives way to a high bit in the three odd/even rows, not in the plain last row
  logic [27:0] oa [4] = '{28'h0000000, 28'h0000002, 28'h0000002, 28'h0000005};

  vpa_core dut (.clock, .nrst, .io_wr, .io_rd, .io_index, .io_wdata, .io_rdata, .pci_mem_en,
    .misc_ram_en, .plane_mask_ctrl, .host_req, .host_we, .host_addr, .host_wdata, .host_ack,
    .host_hit, .host_rdata, .plane_addr, .plane_rd, .plane_we, .plane_wdata, .plane_rdata,
    .gfx_mode);
  vpa_plane_mem mem (.clock, .plane_addr, .plane_rd, .plane_we, .plane_wdata, .plane_rdata);

  always #25 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    @(negedge clock);
    io_wr = 1'b1;
    io_index = idx;
    io_wdata = val;
    @(negedge clock);
    io_wr = 1'b0;
  endtask
  // read data is registered, so it is settled one cycle after the strobe
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] val);
    @(negedge clock);
    io_rd = 1'b1;
    io_index = idx;
    @(negedge clock);
    io_rd = 1'b0;
    val = io_rdata;
  endtask
  // one-cycle request, then a bounded wait for the ack pulse
  task automatic host(input logic we, input logic [19:0] a, input logic [7:0] d);
    int n;
    @(negedge clock);
    host_req = 1'b1;
    host_we = we;
    host_addr = a;
    host_wdata = d;
    @(negedge clock);
    host_req = 1'b0;
    for (n = 0; n < 4 && host_ack !== 1'b1; n++) @(negedge clock);
    check({31'h0, host_ack}, 32'h1);
    seen_w = plane_wdata;
    seen_we = plane_we;
    seen_a = plane_addr;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the sequence needs about 340 cycles
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    foreach (rows[i]) begin
      for (int j = 0; j < 8; j++) reg_wr(ridx[j], rows[i].cfg[71-8*j -: 8]);
      host(1'b0, 20'hA0010, 8'h00);
      if (rows[i].w) begin
        host(1'b1, 20'hA0020, rows[i].cfg[7:0]);
        check(seen_w, rows[i].exp);
      end else
        check({24'h0, host_rdata}, rows[i].exp);
    end
    $display("table rows done");
    @(negedge clock);
    nrst = 1'b0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    reg_rd(`VPA_IDX_BMASK, rd);
    check({24'h0, rd}, 32'hFF);
    reg_rd(`VPA_IDX_PGCTL, rd);
    check({24'h0, rd}, 32'h00);
    $display("reset values done");
    for (int k = 0; k < 2; k++) begin
      pci_mem_en = k[0];
      misc_ram_en = !k[0];
      host(1'b1, 20'hA0000, 8'h00);
      check({31'h0, host_hit}, 32'h0);
    end
    pci_mem_en = 1'b1;
    misc_ram_en = 1'b1;
    for (int m = 0; m < 4; m++) begin
      reg_wr(`VPA_IDX_MMAP, {4'h0, m[1:0], 2'b00});
      for (int k = 0; k < 4; k++) begin
        host(1'b0, ap[k], 8'h00);
        check({31'h0, host_hit}, {31'h0, hm[k][m]});
      end
    end
    reg_wr(`VPA_IDX_MMAP, 8'hFF);
    reg_rd(`VPA_IDX_MMAP, rd);
    check({24'h0, rd}, 32'h0F);
    check({31'h0, gfx_mode}, 32'h1);
    $display("decode done");
    foreach (oe[k]) begin
      reg_wr(`VPA_IDX_MMAP, oe[k][43:36]);
      reg_wr(`VPA_IDX_AMODE, oe[k][35:28]);
      plane_mask_ctrl = oe[k][27:24];
      host(1'b1, oe[k][23:4], 8'h00);
      check({28'h0, seen_we}, {28'h0, oe[k][3:0]});
      check({4'h0, seen_a}, {4'h0, oa[k]});
    end
    plane_mask_ctrl = 4'hF;
    // odd address in chained mode reads the odd plane of the pair
    reg_wr(`VPA_IDX_MMAP, 8'h02);
    reg_wr(`VPA_IDX_RPS, 8'h02);
    host(1'b0, 20'hA0011, 8'h00);
    check({24'h0, host_rdata}, 32'hC3);
    $display("odd/even done");
    reg_wr(`VPA_IDX_MMAP, 8'h04);
    reg_wr(`VPA_IDX_PGLO, 8'h34);
    reg_wr(`VPA_IDX_PGCTL, 8'h51);
    // page number kept small and legal
    host(1'b1, 20'hA1234, 8'h00);
    check({4'h0, seen_a}, 32'h05341234);
    reg_wr(`VPA_IDX_PGCTL, 8'h53);
    host(1'b1, 20'hA1234, 8'h00);
    check({31'h0, host_hit}, 32'h0);
    reg_wr(8'h20, 8'hAA);
    reg_rd(8'h20, rd);
    check({24'h0, rd}, 32'h00);
    $display("paging done");
    tally_and_finish();
  end
endmodule // test_vpa_core

/* bench/vpa_core_assertions.sv */
// vpa_core_assertions.sv: timing checks on the planar access core.
// assumes one clock domain and only the core's top-level ports.
`timescale 1ns/1ps
module vpa_core_checker (
  input logic        clock,
  input logic        nrst,
  input logic        io_wr,
  input logic        io_rd,
  input logic [7:0]  io_index,
  input logic [7:0]  io_wdata,
  input logic [7:0]  io_rdata,
  input logic        pci_mem_en,
  input logic        misc_ram_en,
  input logic [3:0]  plane_mask_ctrl,
  input logic        host_req,
  input logic        host_we,
  input logic [19:0] host_addr,
  input logic [7:0]  host_wdata,
  input logic        host_ack,
  input logic        host_hit,
  input logic [7:0]  host_rdata,
  input logic [27:0] plane_addr,
  input logic        plane_rd,
  input logic [3:0]  plane_we,
  input logic [31:0] plane_wdata,
  input logic [31:0] plane_rdata,
  input logic        gfx_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // a request is dropped while a read sits in its memory cycle
  wire taken = host_req && !plane_rd;
  sequence s_miss;
    host_ack && !host_hit && plane_we == 4'h0;
  endsequence
  sequence s_rd_hit;
    plane_rd ##1 host_ack && host_hit;
  endsequence
  sequence s_misc_wr;
    io_wr && io_index == 8'h06;
  endsequence
  a_read_two_cycles: assert property (taken && !host_we |=> s_rd_hit or s_miss)
    else $error("read not answered in two cycles");
  a_write_one_cycle: assert property (taken && host_we |=> host_ack)
    else $error("write not acknowledged next cycle");
  a_mem_disabled: assert property (taken && !(pci_mem_en && misc_ram_en) |=> s_miss)
    else $error("access claimed with memory disabled");
  a_outside_window: assert property (taken && host_addr[19:17] != 3'b101 |=> s_miss)
    else $error("access outside aperture claimed");
  a_misc_reserved: assert property (io_rd && io_index == 8'h06 |=> io_rdata[7:4] == 4'h0)
    else $error("reserved misc bits not zero");
  a_gfx_follows: assert property (s_misc_wr |=> ##1 gfx_mode == $past(io_wdata[0], 2))
    else $error("graphics mode does not follow register");
  a_we_with_ack: assert property (plane_we != 4'h0 |-> host_ack && host_hit)
    else $error("plane write without claimed ack");
  a_rdata_holds: assert property (!host_ack |-> $stable(host_rdata))
    else $error("read result changed without ack");
  a_rd_no_write: assert property (plane_rd |-> !host_ack && plane_we == 4'h0)
    else $error("plane read overlaps a write or ack");
endmodule // vpa_core_checker
bind vpa_core vpa_core_checker chk (.clock, .nrst, .io_wr, .io_rd, .io_index, .io_wdata,
  .io_rdata, .pci_mem_en, .misc_ram_en, .plane_mask_ctrl, .host_req, .host_we, .host_addr,
  .host_wdata, .host_ack, .host_hit, .host_rdata, .plane_addr, .plane_rd, .plane_we,
  .plane_wdata, .plane_rdata, .gfx_mode);

/* bench/vpa_plane_mem.sv */
// vpa_plane_mem.sv: behavioural four-plane memory on the far side of the core.
// assumes plane_rdata is taken in the cycle that plane_rd is high.
`timescale 1ns/1ps
module vpa_plane_mem #(
  parameter logic [31:0] FILL = 32'hC33CA55A
) (
  input  logic        clock,
  input  logic [27:0] plane_addr,
  input  logic        plane_rd,
  input  logic [3:0]  plane_we,
  input  logic [31:0] plane_wdata,
  output logic [31:0] plane_rdata
);
  logic [31:0] mem [0:63]; // small slice of each plane is enough here
  logic [31:0] last_q;     // last word handed out
  initial begin
    foreach (mem[i]) mem[i] = FILL;
    last_q = FILL;
  end
  // idle bus shows the inverse so stale data never passes for an answer
  assign plane_rdata = plane_rd ? mem[plane_addr[5:0]] : ~last_q;
  // byte lanes written under their own plane enable
  always @(posedge clock) begin
    if (plane_rd) last_q <= mem[plane_addr[5:0]];
    for (int p = 0; p < 4; p++)
      if (plane_we[p]) mem[plane_addr[5:0]][p*8 +: 8] <= plane_wdata[p*8 +: 8];
  end
endmodule // vpa_plane_mem

/* core/vpa_core.v */
// vpa_core.v: planar frame-buffer access datapath with its indexed
// control registers, aperture decode, read modes and write modes.
// assumes a single-cycle plane memory: plane_rdata answers plane_addr
// in the same cycle; memory-enable inputs come from outside registers.
`timescale 1ns/1ps
`include "vpa_regs.vh"
module vpa_core (
  input  wire        clock,
  input  wire        nrst,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_index,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  input  wire        pci_mem_en,
  input  wire        misc_ram_en,
  input  wire [3:0]  plane_mask_ctrl,
  input  wire        host_req,
  input  wire        host_we,
  input  wire [19:0] host_addr,
  input  wire [7:0]  host_wdata,
  output reg         host_ack,
  output reg         host_hit,
  output reg  [7:0]  host_rdata,
  output reg  [27:0] plane_addr,
  output reg         plane_rd,
  output reg  [3:0]  plane_we,
  output reg  [31:0] plane_wdata,
  input  wire [31:0] plane_rdata,
  output reg         gfx_mode
);
  // one-hot access states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RD   = 2'b10;

  // control registers
  reg [3:0]  sr_val_q;      // set/reset value
  reg [3:0]  sr_en_q;       // set/reset enable
  reg [3:0]  cc_val_q;      // color compare value
  reg [4:0]  rot_q;         // function and rotate count
  reg [1:0]  rps_q;         // read plane select
  reg [6:0]  amode_q;       // access mode (bit 2 held zero)
  reg [3:0]  mmap_q;        // memory map and misc
  reg [3:0]  ign_q;         // color ignore mask
  reg [7:0]  bmask_q;       // write bit mask
  reg [7:0]  pgctl_q;       // page mapping control
  reg [7:0]  pglo_q;        // page select low
  reg [31:0] latch_q;       // memory read latches
  reg [1:0]  state_q;       // access sequencer
  reg        rd_a0_q;       // A0 of the pending read

  // decode results
  reg        hit;           // address claimed by the aperture
  reg [16:0] off;           // offset inside the window
  reg [27:0] addr;          // address sent to the planes
  reg [3:0]  wen;           // plane write enables
  reg [7:0]  rd_byte;       // value returned to the host
  reg [7:0]  io_val;        // indexed register readback
  wire [31:0] wr_data;      // data from the write unit
  wire       oe_mode;       // any odd/even plane pairing
  wire       paging;        // paged window active

  assign oe_mode = amode_q[`VPA_AM_OE] | mmap_q[`VPA_MM_CHAIN];
  assign paging  = pgctl_q[`VPA_PG_EN];

  // byte select from a 32-bit plane word
  function [7:0] pbyte;
    input [31:0] w;
    input [1:0]  s;
    begin
      pbyte = w[s*8 +: 8];
    end
  endfunction

  // aperture decode
  always @* begin
    hit = 1'b0;
    off = 17'h0_0000;
    case (mmap_q[`VPA_MM_MAP])
      2'h0: begin
        hit = (host_addr[19:17] == 3'h5);
        off = host_addr[16:0];
      end
      2'h1: begin
        hit = (host_addr[19:16] == 4'hA);
        off = {1'b0, host_addr[15:0]};
      end
      2'h2: begin
        hit = (host_addr[19:15] == 5'h16);
        off = {2'h0, host_addr[14:0]};
      end
      2'h3: begin
        hit = (host_addr[19:15] == 5'h17);
        off = {2'h0, host_addr[14:0]};
      end
      default: hit = 1'b0;
    endcase
    hit = hit & pci_mem_en & misc_ram_en;
    if (paging && (pgctl_q[`VPA_PG_TGT] != 2'h0)) begin
      hit = 1'b0;
    end
  end

  // plane address and plane choice
  always @* begin
    addr = 28'h000_0000;
    wen  = 4'h0;
    if (paging) begin
      addr = {pgctl_q[`VPA_PG_EXT], pglo_q, host_addr[15:2], host_addr[1:0]};
      wen  = plane_mask_ctrl;
    end else if (oe_mode) begin
      addr = {11'h000, 1'b0, off[15:1], off[16]};
      // even to 0/2, odd to 1/3
      wen  = (host_addr[0] ? 4'hA : 4'h5) & plane_mask_ctrl;
      // read plane pairing uses the A0 captured with the read
    end else begin
      addr = {11'h000, off};
      wen  = plane_mask_ctrl;
    end
  end

  // write data path
  vpa_wr_unit u_wr (
    .wmode   (amode_q[`VPA_AM_WMODE]),
    .wdata   (host_wdata),
    .rot_cnt (rot_q[`VPA_ROT_CNT]),
    .fn      (rot_q[`VPA_ROT_FN]),
    .sr_val  (sr_val_q),
    .sr_en   (sr_en_q),
    .bmask   (bmask_q),
    .latch   (latch_q),
    .pdata   (wr_data)
  );

  // read result from the current plane word
  always @* begin
    rd_byte = 8'h00;
    if (amode_q[`VPA_AM_RMODE]) begin
      rd_byte = ~(({8{ign_q[0]}} & (pbyte(plane_rdata, 2'd0) ^ {8{cc_val_q[0]}})) |
                  ({8{ign_q[1]}} & (pbyte(plane_rdata, 2'd1) ^ {8{cc_val_q[1]}})) |
                  ({8{ign_q[2]}} & (pbyte(plane_rdata, 2'd2) ^ {8{cc_val_q[2]}})) |
                  ({8{ign_q[3]}} & (pbyte(plane_rdata, 2'd3) ^ {8{cc_val_q[3]}})));
    end else if (rd_a0_q && oe_mode && !paging) begin
      rd_byte = pbyte(plane_rdata, {rps_q[1], 1'b1});
    end else if (oe_mode && !paging) begin
      rd_byte = pbyte(plane_rdata, {rps_q[1], 1'b0});
    end else begin
      rd_byte = pbyte(plane_rdata, rps_q);
    end
  end

  // indexed register readback
  always @* begin
    case (io_index)
      `VPA_IDX_SR_VAL: io_val = {4'h0, sr_val_q};
      `VPA_IDX_SR_EN:  io_val = {4'h0, sr_en_q};
      `VPA_IDX_CC_VAL: io_val = {4'h0, cc_val_q};
      `VPA_IDX_ROT:    io_val = {3'h0, rot_q};
      `VPA_IDX_RPS:    io_val = {6'h00, rps_q};
      `VPA_IDX_AMODE:  io_val = {1'b0, amode_q};
      `VPA_IDX_MMAP:   io_val = {4'h0, mmap_q};
      `VPA_IDX_IGN:    io_val = {4'h0, ign_q};
      `VPA_IDX_BMASK:  io_val = bmask_q;
      `VPA_IDX_PGCTL:  io_val = pgctl_q;
      `VPA_IDX_PGLO:   io_val = pglo_q;
      default:         io_val = 8'h00;
    endcase
  end

  // register writes and readback flop
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sr_val_q <= `VPA_RST_NIB;
      sr_en_q  <= `VPA_RST_NIB;
      cc_val_q <= `VPA_RST_NIB;
      rot_q    <= 5'h00;
      rps_q    <= 2'h0;
      amode_q  <= 7'h00;
      mmap_q   <= `VPA_RST_NIB;
      ign_q    <= `VPA_RST_NIB;
      bmask_q  <= `VPA_RST_BMASK;
      pgctl_q  <= `VPA_RST_PGCTL;
      pglo_q   <= `VPA_RST_BYTE;
      io_rdata <= `VPA_RST_BYTE;
      gfx_mode <= 1'b0;
    end else begin
      if (io_rd) begin
        io_rdata <= io_val;
      end
      if (io_wr) begin
        case (io_index)
          `VPA_IDX_SR_VAL: sr_val_q <= io_wdata[3:0];
          `VPA_IDX_SR_EN:  sr_en_q  <= io_wdata[3:0];
          `VPA_IDX_CC_VAL: cc_val_q <= io_wdata[3:0];
          `VPA_IDX_ROT:    rot_q    <= io_wdata[4:0];
          `VPA_IDX_RPS:    rps_q    <= io_wdata[1:0];
          // reserved bit 2 kept zero
          `VPA_IDX_AMODE:  amode_q  <= {io_wdata[6:3], 1'b0, io_wdata[1:0]};
          `VPA_IDX_MMAP:   mmap_q   <= io_wdata[3:0];
          `VPA_IDX_IGN:    ign_q    <= io_wdata[3:0];
          `VPA_IDX_BMASK:  bmask_q  <= io_wdata;
          `VPA_IDX_PGCTL:  pgctl_q  <= io_wdata;
          `VPA_IDX_PGLO:   pglo_q   <= io_wdata;
          default:         pglo_q   <= pglo_q;
        endcase
      end
      gfx_mode <= mmap_q[`VPA_MM_GFX];
    end
  end

  // host access sequencer; requests while busy are dropped
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      rd_a0_q     <= 1'b0;
      latch_q     <= 32'h0000_0000;
      host_ack    <= 1'b0;
      host_hit    <= 1'b0;
      host_rdata  <= 8'h00;
      plane_addr  <= 28'h000_0000;
      plane_rd    <= 1'b0;
      plane_we    <= 4'h0;
      plane_wdata <= 32'h0000_0000;
    end else begin
      host_ack <= 1'b0;
      plane_rd <= 1'b0;
      plane_we <= 4'h0;
      case (state_q)
        ST_IDLE: begin
          if (host_req && !hit) begin
            // unclaimed: answer with no hit, no data
            host_ack   <= 1'b1;
            host_hit   <= 1'b0;
            host_rdata <= 8'h00;
          end else if (host_req && host_we) begin
            plane_addr  <= addr;
            plane_we    <= wen;
            plane_wdata <= wr_data;
            host_ack    <= 1'b1;
            host_hit    <= 1'b1;
          end else if (host_req) begin
            plane_addr <= addr;
            plane_rd   <= 1'b1;
            // A0 kept: the host address may move before data returns
            rd_a0_q    <= host_addr[0];
            state_q    <= ST_RD;
          end
        end
        ST_RD: begin
          latch_q    <= plane_rdata;
          host_rdata <= rd_byte;
          host_ack   <= 1'b1;
          host_hit   <= 1'b1;
          state_q    <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // vpa_core

/* core/vpa_wr_unit.v */
// vpa_wr_unit.v: combinational write-data path for the four planes.
// assumes latches and controls are stable registers of the caller.
`timescale 1ns/1ps
`include "vpa_regs.vh"
module vpa_wr_unit (
  input  wire [1:0]  wmode,
  input  wire [7:0]  wdata,
  input  wire [2:0]  rot_cnt,
  input  wire [1:0]  fn,
  input  wire [3:0]  sr_val,
  input  wire [3:0]  sr_en,
  input  wire [7:0]  bmask,
  input  wire [31:0] latch,
  output reg  [31:0] pdata
);
  // rotate right by a 3-bit count
  function [7:0] ror8;
    input [7:0] d;
    input [2:0] n;
    reg   [15:0] w;
    begin
      w    = {d, d} >> n;
      ror8 = w[7:0];
    end
  endfunction

  // logical function against the latch byte
  function [7:0] alu;
    input [1:0] f;
    input [7:0] d;
    input [7:0] l;
    begin
      case (f)
        `VPA_FN_AND: alu = d & l;
        `VPA_FN_OR:  alu = d | l;
        `VPA_FN_XOR: alu = d ^ l;
        default:     alu = d;
      endcase
    end
  endfunction

  reg [7:0] rot;   // rotated host byte
  reg [7:0] src;   // per-plane source before mask
  reg [7:0] m;     // effective bit mask
  reg [7:0] lb;    // latch byte of the plane
  integer   p;

  // per-plane data selection
  always @* begin
    rot   = ror8(wdata, rot_cnt);
    src   = 8'h00;
    m     = 8'h00;
    lb    = 8'h00;
    pdata = 32'h0000_0000;
    for (p = 0; p < 4; p = p + 1) begin
      lb = latch[p*8 +: 8];
      m  = bmask;
      case (wmode)
        `VPA_WM_ROT:    src = alu(fn, sr_en[p] ? {8{sr_val[p]}} : rot, lb);
        `VPA_WM_LATCH:  src = lb;
        `VPA_WM_COLOR:  src = alu(fn, {8{wdata[p]}}, lb);
        `VPA_WM_MASKSR: begin
          src = {8{sr_val[p]}};
          m   = rot & bmask;
        end
        default:        src = lb;
      endcase
      pdata[p*8 +: 8] = (wmode == `VPA_WM_LATCH) ? lb : ((src & m) | (lb & ~m));
    end
  end
endmodule // vpa_wr_unit

/* include/vpa_regs.vh */
// vpa_regs.vh: register indices, field positions and reset values of the
// planar access datapath; definitions only, included by bare name.
`ifndef VPA_REGS_VH
`define VPA_REGS_VH
// indexed register numbers on the index/data port
`define VPA_IDX_SR_VAL   8'h00
`define VPA_IDX_SR_EN    8'h01
`define VPA_IDX_CC_VAL   8'h02
`define VPA_IDX_ROT      8'h03
`define VPA_IDX_RPS      8'h04
`define VPA_IDX_AMODE    8'h05
`define VPA_IDX_MMAP     8'h06
`define VPA_IDX_IGN      8'h07
`define VPA_IDX_BMASK    8'h08
`define VPA_IDX_PGCTL    8'h10
`define VPA_IDX_PGLO     8'h11
// field positions
`define VPA_ROT_CNT      2:0
`define VPA_ROT_FN       4:3
`define VPA_AM_WMODE     1:0
`define VPA_AM_RMODE     3
`define VPA_AM_OE        4
`define VPA_AM_SHIFT     6:5
`define VPA_MM_GFX       0
`define VPA_MM_CHAIN     1
`define VPA_MM_MAP       3:2
`define VPA_PG_EN        0
`define VPA_PG_TGT       2:1
`define VPA_PG_EXT       7:4
// reset values
`define VPA_RST_NIB      4'h0
`define VPA_RST_BYTE     8'h00
`define VPA_RST_BMASK    8'hFF
`define VPA_RST_PGCTL    8'h00
// write modes and logical functions
`define VPA_WM_ROT       2'h0
`define VPA_WM_LATCH     2'h1
`define VPA_WM_COLOR     2'h2
`define VPA_WM_MASKSR    2'h3
`define VPA_FN_PASS      2'h0
`define VPA_FN_AND       2'h1
`define VPA_FN_OR        2'h2
`define VPA_FN_XOR       2'h3
`endif
